// file: tb/test_write_enable_sector_protect.sv
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module test_write_enable_sector_protect;
    logic core_clk = 1'b0, sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, seqEnter = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, writeLatchFlag, seqProgMode, writeCmdGo;
    logic [7:0] statusIn = 8'h00, writeCmdOp;
    logic [10:0] sectorProt;
    logic [23:0] writeCmdAddr;
    int badCount = 0, checksDone = 0, cycles = 0, goCount = 0;

    wesp_link_if link();
    wesp_host u_wesp_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    wesp_device u_wesp_device (.core_clk(core_clk), .sys_rst(sys_rst), .link(link),
        .statusIn(statusIn), .seqEnter(seqEnter), .writeLatchFlag(writeLatchFlag),
        .seqProgMode(seqProgMode), .sectorProt(sectorProt), .writeCmdGo(writeCmdGo),
        .writeCmdOp(writeCmdOp), .writeCmdAddr(writeCmdAddr));
    wesp_link_asserts u_wesp_link_asserts (.core_clk(core_clk), .sys_rst(sys_rst),
        .csN(link.csN), .sck(link.sck), .mosi(link.mosi));

    always #5 core_clk = ~core_clk;

    // ****************
    // Helpers
    // ****************
    always @(posedge core_clk)
    begin
        cycles++;
        if (writeCmdGo === 1'b1)
            goCount++;
        if (cycles == 60000)
        begin
            badCount++;
            wrapUp();
        end
    end

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input logic [7:0] op, input logic [5:0] n, input logic [23:0] a);
        logic [31:0] r;
        apb(1'b1, wesp_pkg::ADDR_ADDRESS, {8'h00, a}, r);
        apb(1'b1, wesp_pkg::ADDR_CMD, {18'h00000, n, op}, r);
        r = 32'h00000001;
        while (r[0] !== 1'b0)
            apb(1'b0, wesp_pkg::ADDR_STATUS, 32'h0, r);
        repeat (12) @(posedge core_clk);
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic tReset();
        logic [31:0] r;
        chk("prot", {21'h0, sectorProt}, 32'h000007FF);
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        apb(1'b0, 12'h00C, 32'h0, r);
        chk("unmapped", r, 32'h0);
        chk("slverr", {31'h0, pslverr}, 32'h0);
        apb(1'b1, wesp_pkg::ADDR_ADDRESS, 32'h00ABCDEF, r);
        apb(1'b0, wesp_pkg::ADDR_ADDRESS, 32'h0, r);
        chk("address reg", r, 32'h00ABCDEF);
    endtask

    task automatic tMidReset();
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("prot", {21'h0, sectorProt}, 32'h000007FF);
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        chk("seq", {31'h0, seqProgMode}, 32'h0);
    endtask

    task automatic tLatch();
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h07, 24'h0);
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        chk("latch", {31'h0, writeLatchFlag}, 32'h1);
        send(wesp_pkg::OP_WRITE_DISABLE, 6'h07, 24'h0);
        chk("latch", {31'h0, writeLatchFlag}, 32'h1);
        send(wesp_pkg::OP_WRITE_DISABLE, 6'h10, 24'hFFFFFF);
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h20, 24'hFFFFFF);
        chk("latch", {31'h0, writeLatchFlag}, 32'h1);
        send(wesp_pkg::OP_WRITE_DISABLE, 6'h08, 24'h0);
    endtask

    task automatic tSectors();
        logic [23:0] adr [11] = '{24'h000000, 24'h010000, 24'h020000, 24'h030000,
            24'h040000, 24'h050000, 24'h060000, 24'h070000, 24'h078000, 24'h07A000,
            24'h07C000};
        logic [10:0] exp;
        exp = 11'h7FF;
        send(wesp_pkg::OP_UNPROTECT, 6'h20, adr[0]);
        chk("prot", {21'h0, sectorProt}, {21'h0, exp});
        for (int i = 0; i < 11; i++)
        begin
            send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
            send(wesp_pkg::OP_UNPROTECT, 6'h20, adr[i]);
            exp[i] = 1'b0;
            chk("prot", {21'h0, sectorProt}, {21'h0, exp});
            chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        end
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        send(wesp_pkg::OP_PROTECT, 6'h20, adr[5]);
        exp[5] = 1'b1;
        chk("prot", {21'h0, sectorProt}, {21'h0, exp});
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        send(wesp_pkg::OP_PROTECT, 6'h14, adr[2]);
        chk("prot", {21'h0, sectorProt}, {21'h0, exp});
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        statusIn <= 8'h80;
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        send(wesp_pkg::OP_PROTECT, 6'h20, adr[0]);
        chk("prot", {21'h0, sectorProt}, {21'h0, exp});
        chk("latch", {31'h0, writeLatchFlag}, 32'h0);
        statusIn <= 8'h00;
    endtask

    task automatic tSeqAndGo();
        int g;
        logic [7:0] ops [5] = '{wesp_pkg::OP_SEQ_PROGRAM, wesp_pkg::OP_ERASE_4K,
            wesp_pkg::OP_ERASE_32K, wesp_pkg::OP_CHIP_ERASE_A, wesp_pkg::OP_CHIP_ERASE_B};
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        seqEnter <= 1'b1;
        @(posedge core_clk);
        seqEnter <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("seq", {31'h0, seqProgMode}, 32'h1);
        send(wesp_pkg::OP_WRITE_DISABLE, 6'h08, 24'h0);
        chk("seq", {31'h0, seqProgMode}, 32'h0);
        g = goCount;
        send(wesp_pkg::OP_ERASE_4K, 6'h20, 24'h012345);
        chk("go", goCount, g);
        send(wesp_pkg::OP_WRITE_ENABLE, 6'h08, 24'h0);
        send(wesp_pkg::OP_ERASE_64K, 6'h20, 24'h054321);
        chk("go", goCount, g + 1);
        chk("op", {24'h0, writeCmdOp}, 32'h000000D8);
        chk("addr", {8'h0, writeCmdAddr}, 32'h00054321);
        foreach (ops[k])
        begin
            send(ops[k], 6'h20, 24'h000100);
            chk("go", goCount, g + 2 + k);
            chk("op", {24'h0, writeCmdOp}, {24'h0, ops[k]});
        end
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        tReset();
        tLatch();
        tSectors();
        tSeqAndGo();
        tMidReset();
        wrapUp();
    end
endmodule // test_write_enable_sector_protect

// file: tb/wesp_link_asserts.sv
// Checker of the serial link between host and device ends
`timescale 1ns/1ps
module wesp_link_asserts
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic mosi
);
    logic [6:0] bitCnt;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Serial clock rises seen in the current frame
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            bitCnt <= 7'h00;
        else if (csN)
            bitCnt <= 7'h00;
        else if ($rose(sck))
            bitCnt <= bitCnt + 7'h01;
    end

    sequence sckHigh;
        sck [*4] ##1 !sck;
    endsequence
    sequence gapHigh;
        csN [*4];
    endsequence

    idle_sck_low_a: assert property (csN |-> !sck)
        else $error("serial clock high while deselected");
    sck_high_len_a: assert property ($rose(sck) |-> sckHigh)
        else $error("serial clock high phase wrong length");
    sck_low_len_a: assert property ($fell(sck) |-> !sck [*4])
        else $error("serial clock low phase too short");
    mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("data moved while serial clock high");
    frame_start_a: assert property ($fell(csN) |-> !sck ##[1:8] sck)
        else $error("no serial clock after select");
    frame_end_a: assert property ($rose(csN) |-> !$past(sck))
        else $error("deselect while serial clock high");
    frame_gap_a: assert property ($rose(csN) |-> gapHigh)
        else $error("deselect gap too short");
    bit_limit_a: assert property (bitCnt <= 7'h20)
        else $error("more than 32 bits in one frame");
endmodule // wesp_link_asserts

// file: verilog/wesp_device.sv
// Device end: write-enable latch and per-sector protection command logic
`timescale 1ns/1ps
module wesp_device
#(
    parameter int NSECT = wesp_pkg::NUM_SECTORS
)
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    wesp_link_if.dev            link,
    input  wire logic [7:0]     statusIn,
    input  wire logic           seqEnter,
    output logic                writeLatchFlag,
    output logic                seqProgMode,
    output logic [NSECT-1:0]    sectorProt,
    output logic                writeCmdGo,
    output logic [7:0]          writeCmdOp,
    output logic [23:0]         writeCmdAddr
);
    // ******************************************************
    // Link synchronisers
    // ******************************************************
    logic csS;
    logic csRise;
    logic csFall;
    logic sckRise;
    logic mosiS;

    wesp_sync
    #(
        .RST_VAL (1'b1)
    )
    u_cs
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (link.csN),
        .dout     (csS),
        .rise     (csRise),
        .fall     (csFall)
    );
    wesp_sync
    #(
        .RST_VAL (1'b0)
    )
    u_sck
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (link.sck),
        .dout     (),
        .rise     (sckRise),
        .fall     ()
    );
    wesp_sync
    #(
        .RST_VAL (1'b0)
    )
    u_mosi
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (link.mosi),
        .dout     (mosiS),
        .rise     (),
        .fall     ()
    );

    // ******************************************************
    // Serial shift and bit count
    // ******************************************************
    logic [31:0] shiftReg;
    logic [5:0]  bitCnt;
    logic [23:0] addrReg;
    logic        protLocked;

    assign protLocked = statusIn[wesp_pkg::STATUS_LOCK_BIT];

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shiftReg <= 32'h0000_0000;
            bitCnt   <= 6'h00;
        end
        else if (csFall)
        begin
            shiftReg <= 32'h0000_0000;
            bitCnt   <= 6'h00;
        end
        else if (!csS && sckRise && bitCnt != wesp_pkg::FRAME_BITS)
        begin
            shiftReg <= {shiftReg[30:0], mosiS};
            bitCnt   <= bitCnt + 6'h01;
        end
    end

    assign addrReg = shiftReg[23:0];

    // ******************************************************
    // Sector decode of the address
    // ******************************************************
    function automatic logic [3:0] sectorOf(input logic [23:0] a);
        if (a[18:16] != 3'h7)
            sectorOf = {1'b0, a[18:16]};
        else if (!a[15])
            sectorOf = 4'h7;
        else if (a[14])
            sectorOf = 4'hA;
        else if (!a[13])
            sectorOf = 4'h8;
        else
            sectorOf = 4'h9;
    endfunction

    // ******************************************************
    // Command decode at deselect
    // ******************************************************
    logic [7:0] frameOp;
    logic       opDone;
    logic       addrDone;
    logic       isProtCmd;
    logic       isWriteClass;

    // Opcode byte is the top byte once the frame is full, else the oldest eight
    always_comb
    begin
        frameOp = 8'h00;
        if (bitCnt >= wesp_pkg::FRAME_BITS)
            frameOp = shiftReg[31:24];
        else if (bitCnt >= wesp_pkg::OPCODE_BITS)
            frameOp = 8'((shiftReg >> (bitCnt - wesp_pkg::OPCODE_BITS)) & 32'h0000_00FF);
    end

    assign opDone    = bitCnt >= wesp_pkg::OPCODE_BITS;
    assign addrDone  = bitCnt == wesp_pkg::FRAME_BITS;
    assign isProtCmd = frameOp == wesp_pkg::OP_PROTECT || frameOp == wesp_pkg::OP_UNPROTECT;
    assign isWriteClass = frameOp == wesp_pkg::OP_SEQ_PROGRAM
                       || frameOp == wesp_pkg::OP_ERASE_4K
                       || frameOp == wesp_pkg::OP_ERASE_32K
                       || frameOp == wesp_pkg::OP_ERASE_64K
                       || frameOp == wesp_pkg::OP_CHIP_ERASE_A
                       || frameOp == wesp_pkg::OP_CHIP_ERASE_B;

    // ******************************************************
    // Write-enable latch
    // ******************************************************
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            writeLatchFlag <= 1'b0;
        else if (csRise && opDone)
        begin
            if (frameOp == wesp_pkg::OP_WRITE_ENABLE)
                writeLatchFlag <= 1'b1;
            else if (frameOp == wesp_pkg::OP_WRITE_DISABLE)
                writeLatchFlag <= 1'b0;
            else if (isProtCmd)
                writeLatchFlag <= 1'b0;
        end
    end

    // ******************************************************
    // Sequential programming mode
    // ******************************************************
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            seqProgMode <= 1'b0;
        else if (csRise && opDone && frameOp == wesp_pkg::OP_WRITE_DISABLE)
            seqProgMode <= 1'b0;
        else if (seqEnter && writeLatchFlag)
            seqProgMode <= 1'b1;
    end

    // ******************************************************
    // Sector protection bits
    // ******************************************************
    logic [3:0] tgtSector;
    assign tgtSector = sectorOf(addrReg);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sectorProt <= NSECT'(wesp_pkg::SECTOR_PROT_RST);
        else if (csRise && addrDone && isProtCmd && writeLatchFlag && !protLocked
                 && int'(tgtSector) < NSECT)
            sectorProt[tgtSector] <= (frameOp == wesp_pkg::OP_PROTECT);
    end

    // ******************************************************
    // Accepted write-class command strobe
    // ******************************************************
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            writeCmdGo   <= 1'b0;
            writeCmdOp   <= 8'h00;
            writeCmdAddr <= 24'h00_0000;
        end
        else
        begin
            writeCmdGo <= csRise && opDone && isWriteClass && writeLatchFlag;
            if (csRise && opDone)
            begin
                writeCmdOp   <= frameOp;
                writeCmdAddr <= addrReg;
            end
        end
    end
endmodule // wesp_device

// file: verilog/wesp_host.sv
// Host end: APB-programmed serial command sender
`timescale 1ns/1ps
module wesp_host
#(
    parameter int HALF = wesp_pkg::SCK_HALF_CYCLES
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    wesp_link_if.host        link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    // ******************************************************
    // APB registers
    // ******************************************************
    logic [7:0]  cmdOp;
    logic [5:0]  cmdBits;
    logic [23:0] cmdAddr;
    logic        startReq;
    logic        busy;
    logic        wrEn;
    wesp_pkg::wesp_host_state_t state;

    assign busy = state != wesp_pkg::HS_IDLE;
    assign wrEn = psel && penable && pready && pwrite;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite)
            begin
                unique case (paddr)
                    wesp_pkg::ADDR_CMD:     prdata <= {18'h0_0000, cmdBits, cmdOp};
                    wesp_pkg::ADDR_ADDRESS: prdata <= {8'h00, cmdAddr};
                    wesp_pkg::ADDR_STATUS:  prdata <= {31'h0000_0000, busy};
                    default:                prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmdOp    <= 8'h00;
            cmdBits  <= 6'h00;
            cmdAddr  <= 24'h00_0000;
            startReq <= 1'b0;
        end
        else
        begin
            startReq <= 1'b0;
            if (wrEn && paddr == wesp_pkg::ADDR_ADDRESS)
                cmdAddr <= pwdata[23:0];
            if (wrEn && paddr == wesp_pkg::ADDR_CMD && !busy)
            begin
                cmdOp    <= pwdata[wesp_pkg::CMD_OP_LSB +: 8];
                cmdBits  <= pwdata[wesp_pkg::CMD_NBITS_LSB +: 6];
                startReq <= 1'b1;
            end
        end
    end

    // ******************************************************
    // Serial clock divider
    // ******************************************************
    logic [7:0] divCnt;
    logic       tick;
    assign tick = divCnt == 8'(HALF - 1);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            divCnt <= 8'h00;
        else if (!busy || tick)
            divCnt <= 8'h00;
        else
            divCnt <= divCnt + 8'h01;
    end

    // ******************************************************
    // Frame sequencer, mode 0, MSB first
    // ******************************************************
    logic [31:0] frame;
    logic [5:0]  sent;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state     <= wesp_pkg::HS_IDLE;
            link.csN  <= 1'b1;
            link.sck  <= 1'b0;
            link.mosi <= 1'b0;
            frame     <= 32'h0000_0000;
            sent      <= 6'h00;
        end
        else
        begin
            unique case (state)
                wesp_pkg::HS_IDLE:
                begin
                    if (startReq)
                    begin
                        frame     <= {cmdOp, cmdAddr};
                        link.mosi <= cmdOp[7];
                        link.csN  <= 1'b0;
                        sent      <= 6'h00;
                        state     <= (cmdBits == 6'h00) ? wesp_pkg::HS_DONE
                                                        : wesp_pkg::HS_SHIFT;
                    end
                end
                wesp_pkg::HS_SHIFT:
                begin
                    if (tick && !link.sck)
                        link.sck <= 1'b1;
                    else if (tick)
                    begin
                        link.sck  <= 1'b0;
                        link.mosi <= frame[30];
                        frame     <= {frame[30:0], 1'b0};
                        sent      <= sent + 6'h01;
                        if (sent + 6'h01 >= cmdBits || sent + 6'h01 == wesp_pkg::FRAME_BITS)
                            state <= wesp_pkg::HS_DONE;
                    end
                end
                wesp_pkg::HS_DONE:
                begin
                    if (tick)
                    begin
                        link.csN <= 1'b1;
                        state    <= wesp_pkg::HS_IDLE;
                    end
                end
                default:
                    state <= wesp_pkg::HS_IDLE;
            endcase
        end
    end
endmodule // wesp_host

// file: verilog/wesp_link_if.sv
// Serial link between the host controller and the device command logic
`timescale 1ns/1ps
interface wesp_link_if;
    logic csN;
    logic sck;
    logic mosi;
    modport host (output csN, output sck, output mosi);
    modport dev  (input csN, input sck, input mosi);
endinterface

// file: verilog/wesp_pkg.sv
// Package of shared constants for the write-enable and sector-protect command logic
package wesp_pkg;
    localparam logic [7:0]  OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0]  OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0]  OP_PROTECT       = 8'h36;
    localparam logic [7:0]  OP_UNPROTECT     = 8'h39;
    localparam logic [7:0]  OP_SEQ_PROGRAM   = 8'hAF;
    localparam logic [7:0]  OP_ERASE_4K      = 8'h20;
    localparam logic [7:0]  OP_ERASE_32K     = 8'h52;
    localparam logic [7:0]  OP_ERASE_64K     = 8'hD8;
    localparam logic [7:0]  OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0]  OP_CHIP_ERASE_B  = 8'hC7;
    localparam int          NUM_SECTORS      = 11;
    localparam int          STATUS_LOCK_BIT  = 7;
    localparam logic [5:0]  OPCODE_BITS      = 6'h08;
    localparam logic [5:0]  FRAME_BITS       = 6'h20;
    localparam logic [10:0] SECTOR_PROT_RST  = 11'h7FF;
    localparam logic [11:0] ADDR_CMD         = 12'h000;
    localparam logic [11:0] ADDR_ADDRESS     = 12'h004;
    localparam logic [11:0] ADDR_STATUS      = 12'h008;
    localparam int          CMD_OP_LSB       = 0;
    localparam int          CMD_NBITS_LSB    = 8;
    localparam int          STATUS_BUSY_BIT  = 0;
    localparam int          SCK_HALF_CYCLES  = 4;
    typedef enum logic [1:0]
    {
        HS_IDLE  = 2'b00,
        HS_SHIFT = 2'b01,
        HS_DONE  = 2'b10
    } wesp_host_state_t;
endpackage

// file: verilog/wesp_sync.sv
// Two-stage synchroniser with edge outputs taken after the second stage
`timescale 1ns/1ps
module wesp_sync
#(
    parameter logic RST_VAL = 1'b1
)
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic prev;
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta <= RST_VAL;
            dout <= RST_VAL;
            prev <= RST_VAL;
        end
        else
        begin
            meta <= din;
            dout <= meta;
            prev <= dout;
        end
    end
    assign rise = dout & ~prev;
    assign fall = ~dout & prev;
endmodule // wesp_sync
